// [src/stt_timer.sv]
// Top of the system tick timer: APB register slave, control bits, count flag and exception pend output.
// Assumes an APB master in pclk's domain and an exception controller that takes tick_pend as a one-cycle request.
`timescale 1ns/1ps

// How it works
// [RULE_01] Counter reaching zero sets sticky flag bit 16.
// [RULE_02] A control register read that returns the flag set clears it.
// [RULE_03] Bit 2 picks CPU clock or reference.
// [RULE_04] Bit 1 pends exception at each zero.
// [RULE_05] Enable write loads reload and starts counting.
// [RULE_06] 24-bit reload value copied at each zero.
// [RULE_07] Reference tick is oscillator input divided by 32.
// [RULE_08] Current register reads the live 24-bit count.
// [RULE_09] Any write to current forces count zero.
// [RULE_10] That write also clears the count flag.
// [RULE_11] Calibration field reads fixed ten millisecond reload.
// [RULE_12] Calibration bits 31 and 30 read zero.
// [RULE_13] Decrement per tick, reload after reaching zero.
// [RULE_14] Unused bits read zero, ignore writes.
module stt_timer import stt_pkg::*; (
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write byte strobes.
  input wire logic oscillator_input, // Oscillator input pin.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  output logic tick_pend // Exception pend request, one cycle.
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic enable_r;
  logic tick_exception_enable_r;
  logic count_clock_select_r;
  logic count_flag_r;
  logic count_flag_nxt;
  logic [23:0] reload_r;
  logic [23:0] reload_nxt;
  logic [23:0] count;
  logic zero_pulse;
  logic ref_tick;
  logic count_tick;

  logic hit_csr;
  logic hit_reload;
  logic hit_current;
  logic hit_calib;
  logic hit_any;
  logic acc_wait;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic csr_wr;
  logic enable_rise;
  logic flag_read_clr;
  logic current_clr;
  logic [31:0] csr_word;
  logic [31:0] reload_word;
  logic [31:0] current_word;
  logic [31:0] calib_word;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Address decode and bus phases
  // ----------------------------------------------------------------
  assign hit_csr = (paddr == OFF_CSR);
  assign hit_reload = (paddr == OFF_RELOAD);
  assign hit_current = (paddr == OFF_CURRENT);
  assign hit_calib = (paddr == OFF_CALIB);
  assign hit_any = hit_csr | hit_reload | hit_current | hit_calib;

  // Every access gets one wait state; the write acts at the edge where pready is seen high.
  assign acc_wait = psel & penable & ~pready;
  assign acc_done = psel & penable & pready;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign csr_wr = wr_done & hit_csr & pstrb[0];
  assign enable_rise = csr_wr & pwdata[CSR_ENABLE] & ~enable_r; // [RULE_05]
  assign current_clr = wr_done & hit_current; // [RULE_09]

  // Only a flag value that the reader actually saw is cleared, so a zero arriving during the access survives.
  assign flag_read_clr = rd_done & hit_csr & prdata[CSR_FLAG]; // [RULE_02]
  assign count_flag_nxt = zero_pulse | (count_flag_r & ~flag_read_clr & ~current_clr); // [RULE_01] [RULE_10]

  assign reload_nxt[7:0] = (wr_done & hit_reload & pstrb[0]) ? pwdata[7:0] : reload_r[7:0]; // [RULE_06]
  assign reload_nxt[15:8] = (wr_done & hit_reload & pstrb[1]) ? pwdata[15:8] : reload_r[15:8]; // [RULE_06]
  assign reload_nxt[23:16] = (wr_done & hit_reload & pstrb[2]) ? pwdata[23:16] : reload_r[23:16]; // [RULE_06]

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign csr_word = {15'h0000, count_flag_r, 13'h0000, count_clock_select_r,
                     tick_exception_enable_r, enable_r}; // [RULE_14]
  assign reload_word = {8'h00, reload_r}; // [RULE_14]
  assign current_word = {8'h00, count}; // [RULE_08]
  assign calib_word = {NO_REF_CLOCK_VAL, CAL_INEXACT_VAL, 6'h00, TEN_MS_RELOAD}; // [RULE_11] [RULE_12]
  assign rd_word = hit_csr ? csr_word :
                   hit_reload ? reload_word :
                   hit_current ? current_word :
                   hit_calib ? calib_word : WORD_ZERO;

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  assign count_tick = enable_r & (count_clock_select_r | ref_tick); // [RULE_03]

  stt_refdiv u_refdiv (
    .pclk(pclk),
    .presetn(presetn),
    .osc_in(oscillator_input),
    .ref_tick(ref_tick)
  );

  stt_downcnt u_downcnt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(count_tick),
    .load(enable_rise),
    .clear(current_clr),
    .reload(reload_r),
    .count(count),
    .zero_pulse(zero_pulse)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= CSR_BIT_RST;
      tick_exception_enable_r <= CSR_BIT_RST;
      count_clock_select_r <= CSR_BIT_RST;
    end else if (csr_wr) begin
      enable_r <= pwdata[CSR_ENABLE]; // [RULE_05]
      tick_exception_enable_r <= pwdata[CSR_EXC_EN]; // [RULE_04]
      count_clock_select_r <= pwdata[CSR_CLKSEL]; // [RULE_03]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_flag_r <= CSR_BIT_RST;
      reload_r <= RELOAD_RST;
      tick_pend <= 1'b0;
    end else begin
      count_flag_r <= count_flag_nxt; // [RULE_01]
      reload_r <= reload_nxt;
      tick_pend <= zero_pulse & tick_exception_enable_r; // [RULE_04]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= WORD_ZERO;
    end else begin
      pready <= acc_wait;
      pslverr <= acc_wait & ~hit_any;
      prdata <= (acc_wait & ~pwrite) ? rd_word : WORD_ZERO; // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    zero_pulse |=> count_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Flag not set after zero."); // [RULE_01]

  property p_read_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd_done && hit_csr && prdata[CSR_FLAG] && !zero_pulse) |=> !count_flag_r;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Flag not cleared by read."); // [RULE_02]

  property p_cpu_rate;
    @(posedge pclk) disable iff (!presetn)
    (enable_r && count_clock_select_r && count != COUNT_RST && !current_clr && !enable_rise)
      |=> count == $past(count) - 24'h000001;
  endproperty
  a_cpu_rate: assert property (p_cpu_rate) else $error("Count did not step on CPU clock."); // [RULE_03]

  property p_ref_hold;
    @(posedge pclk) disable iff (!presetn)
    (enable_r && !count_clock_select_r && !ref_tick && !current_clr && !enable_rise && !csr_wr)
      |=> count == $past(count);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("Count moved without reference tick."); // [RULE_03]

  property p_pend;
    @(posedge pclk) disable iff (!presetn)
    zero_pulse |=> (tick_pend == $past(tick_exception_enable_r));
  endproperty
  a_pend: assert property (p_pend) else $error("Pend output wrong at zero."); // [RULE_04]

  property p_no_pend;
    @(posedge pclk) disable iff (!presetn)
    !zero_pulse |=> !tick_pend;
  endproperty
  a_no_pend: assert property (p_no_pend) else $error("Pend without zero."); // [RULE_04]

  property p_enable_load;
    @(posedge pclk) disable iff (!presetn)
    enable_rise |=> (count == $past(reload_r)) && enable_r;
  endproperty
  a_enable_load: assert property (p_enable_load) else $error("Enable did not load."); // [RULE_05]

  property p_reload_at_zero;
    @(posedge pclk) disable iff (!presetn)
    (count_tick && count == COUNT_RST && !current_clr && !enable_rise) |=> count == $past(reload_r);
  endproperty
  a_reload_at_zero: assert property (p_reload_at_zero) else $error("No reload at zero."); // [RULE_06]

  property p_ref_spacing;
    @(posedge pclk) disable iff (!presetn)
    ref_tick |=> !ref_tick [*8];
  endproperty
  a_ref_spacing: assert property (p_ref_spacing) else $error("Reference ticks too close."); // [RULE_07]

  property p_current_read;
    @(posedge pclk) disable iff (!presetn)
    (acc_wait && !pwrite && hit_current) |=> prdata == {8'h00, $past(count)};
  endproperty
  a_current_read: assert property (p_current_read) else $error("Current read wrong."); // [RULE_08]

  property p_current_clear;
    @(posedge pclk) disable iff (!presetn)
    current_clr |=> (count == COUNT_RST) && (!count_flag_r || $past(zero_pulse));
  endproperty
  a_current_clear: assert property (p_current_clear) else $error("Current write did not clear."); // [RULE_09] [RULE_10]

  property p_calib;
    @(posedge pclk) disable iff (!presetn)
    (acc_wait && !pwrite && hit_calib) |=> prdata == 32'h000009C4;
  endproperty
  a_calib: assert property (p_calib) else $error("Calibration word wrong."); // [RULE_11] [RULE_12]

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    (acc_wait && !pwrite && hit_csr) |=> (prdata & 32'hFFFEFFF8) == WORD_ZERO;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused bits not zero."); // [RULE_14]

  property p_decrement;
    @(posedge pclk) disable iff (!presetn)
    (count_tick && count != COUNT_RST && !current_clr && !enable_rise) |=> count < $past(count);
  endproperty
  a_decrement: assert property (p_decrement) else $error("Count did not decrement."); // [RULE_13]

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("Ready held longer than one cycle.");

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
    acc_wait |=> pready;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("Ready late after access phase.");

  property p_prdata_idle;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == WORD_ZERO;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("Read data not zero outside ready.");

  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (acc_wait && !hit_any) |=> pslverr && (prdata == WORD_ZERO);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("Unmapped access not refused."); // [RULE_14]

  property p_unused_reload;
    @(posedge pclk) disable iff (!presetn)
    (acc_wait && !pwrite && hit_reload) |=> prdata[31:24] == 8'h00;
  endproperty
  a_unused_reload: assert property (p_unused_reload) else $error("Reload upper byte not zero."); // [RULE_14]

  property p_reload_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && hit_reload && pstrb[2:0] == 3'h7) |=> reload_r == $past(pwdata[23:0]);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("Reload write lost."); // [RULE_06]

  property p_reload_partial;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && hit_reload && !pstrb[2]) |=> reload_r[23:16] == $past(reload_r[23:16]);
  endproperty
  a_reload_partial: assert property (p_reload_partial) else $error("Unstrobed reload byte changed."); // [RULE_06]

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    (count_flag_r && !flag_read_clr && !current_clr) |=> count_flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag dropped without clear."); // [RULE_01]

  property p_flag_no_spurious;
    @(posedge pclk) disable iff (!presetn)
    (!count_flag_r && !zero_pulse) |=> !count_flag_r;
  endproperty
  a_flag_no_spurious: assert property (p_flag_no_spurious) else $error("Flag set without zero."); // [RULE_01]

  property p_zero_event;
    @(posedge pclk) disable iff (!presetn)
    zero_pulse |-> count == COUNT_RST;
  endproperty
  a_zero_event: assert property (p_zero_event) else $error("Zero event with nonzero count."); // [RULE_13]

  property p_disabled_frozen;
    @(posedge pclk) disable iff (!presetn)
    (!enable_r && !enable_rise && !current_clr) |=> count == $past(count);
  endproperty
  a_disabled_frozen: assert property (p_disabled_frozen) else $error("Count moved while disabled."); // [RULE_05]

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
    csr_wr |=> (enable_r == $past(pwdata[CSR_ENABLE])) &&
               (count_clock_select_r == $past(pwdata[CSR_CLKSEL]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("Control bits not written."); // [RULE_03] [RULE_05]

  property p_pend_masked;
    @(posedge pclk) disable iff (!presetn)
    !tick_exception_enable_r |=> !tick_pend;
  endproperty
  a_pend_masked: assert property (p_pend_masked) else $error("Pend while exception disabled."); // [RULE_04]

  property p_ref_rise;
    @(posedge pclk) disable iff (!presetn)
    ref_tick |-> $past(oscillator_input) && !$past(oscillator_input, 2);
  endproperty
  a_ref_rise: assert property (p_ref_rise) else $error("Reference tick without oscillator rise."); // [RULE_07]

  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) zero_pulse ##1 tick_pend);
  c_read_clear: cover property (@(posedge pclk) disable iff (!presetn) flag_read_clr);
  c_ref_count: cover property (@(posedge pclk) disable iff (!presetn) ref_tick && count_tick);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_current_clear: cover property (@(posedge pclk) disable iff (!presetn) current_clr && count_flag_r);

endmodule // stt_timer

// [src/stt_pkg.sv]
// Constants shared by the system tick timer: register map, field positions, reset values and divider figures.
// Assumes a 32-bit APB register port with a 12-bit byte address inside the timer's window.
package stt_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CSR = 12'h010;
  localparam logic [11:0] OFF_RELOAD = 12'h014;
  localparam logic [11:0] OFF_CURRENT = 12'h018;
  localparam logic [11:0] OFF_CALIB = 12'h01C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int CSR_ENABLE = 0;
  localparam int CSR_EXC_EN = 1;
  localparam int CSR_CLKSEL = 2;
  localparam int CSR_FLAG = 16;
  localparam int CAL_NO_REFERENCE_CLOCK = 31;
  localparam int CAL_CALIBRATION_INEXACT = 30;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic CSR_BIT_RST = 1'b0;
  localparam logic [23:0] RELOAD_RST = 24'h000000;
  localparam logic [23:0] COUNT_RST = 24'h000000;
  localparam logic [23:0] TEN_MS_RELOAD = 24'h0009C4;
  localparam logic NO_REF_CLOCK_VAL = 1'b0;
  localparam logic CAL_INEXACT_VAL = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // ----------------------------------------------------------------
  // Reference clock divider
  // ----------------------------------------------------------------
  localparam int REF_DIV = 32;
  localparam int REF_DIV_W = 5;
  localparam logic [4:0] REF_DIV_LAST = 5'h1F;
  localparam logic [4:0] REF_DIV_RST = 5'h00;

endpackage

// [src/stt_refdiv.sv]
// Reference tick generator: one pulse for every 32 rising edges of the oscillator input.
// Assumes the oscillator input is synchronous to pclk and much slower than it.
`timescale 1ns/1ps
module stt_refdiv import stt_pkg::*; (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic osc_in, // Oscillator input level.
  output logic ref_tick // One-cycle reference tick.
);

  logic osc_prev_r;
  logic [4:0] div_r;
  logic [4:0] div_nxt;
  logic osc_rise;

  assign osc_rise = osc_in & ~osc_prev_r;
  assign div_nxt = osc_rise ? div_r + 5'h01 : div_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_r <= 1'b0;
      div_r <= REF_DIV_RST;
      ref_tick <= 1'b0;
    end else begin
      osc_prev_r <= osc_in;
      div_r <= div_nxt; // [RULE_07]
      ref_tick <= osc_rise & (div_r == REF_DIV_LAST); // [RULE_07]
    end
  end

endmodule // stt_refdiv

// [src/stt_downcnt.sv]
// The 24-bit down counter with reload, load on enable and forced clear.
// Assumes tick is already gated by the enable bit.
`timescale 1ns/1ps
module stt_downcnt import stt_pkg::*; (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic tick, // Count tick, one cycle.
  input wire logic load, // Load from the reload value.
  input wire logic clear, // Force the count to zero.
  input wire logic [23:0] reload, // Reload value.
  output logic [23:0] count, // Present count.
  output logic zero_pulse // Count has just reached zero.
);

  logic at_zero;
  logic [23:0] count_nxt;

  assign at_zero = (count == COUNT_RST);
  assign count_nxt = clear ? COUNT_RST :
                     load ? reload :
                     !tick ? count :
                     at_zero ? reload : count - 24'h000001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RST;
      zero_pulse <= 1'b0;
    end else begin
      count <= count_nxt; // [RULE_13]
      zero_pulse <= ~clear & ~load & tick & (count == 24'h000001); // [RULE_01]
    end
  end

endmodule // stt_downcnt

// [verification/tb.sv]
// Self-checking bench for the system tick timer top, driven over APB.
// Assumes stt_pkg and the timer sources are compiled first; the oscillator is synchronous to pclk.
`timescale 1ns/1ps
module tb;
  import stt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic osc = 1'b0;
  logic osc_run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick_pend;
  int error_cnt = 0;
  int samples_checked = 0;
  int pend_cnt = 0;
  int osc_div = 0;

  stt_timer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .oscillator_input(osc), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick_pend(tick_pend));

  always #5 pclk = ~pclk;

  // Oscillator with a period of four pclk cycles.
  always @(posedge pclk) begin
    if (osc_run) begin
      osc_div <= osc_div + 1;
      if (osc_div % 2 == 1) osc <= ~osc;
    end
    if (tick_pend === 1'b1) pend_cnt <= pend_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", n, 32'h00000002);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, 4'hF, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h00000000, 4'h0, r, e);
    chk(name, r, exp);
  endtask

  task automatic wait_pend(output int n, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick_pend !== 1'b1 && n < lim);
    chk("pend_seen", {31'h0, tick_pend}, 32'h00000001);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset_map();
    logic [31:0] r;
    logic e;
    rd_chk(OFF_CSR, 32'h00000000, "csr_rst");
    rd_chk(OFF_RELOAD, 32'h00000000, "reload_rst");
    rd_chk(OFF_CURRENT, 32'h00000000, "current_rst");
    wr(OFF_CALIB, 32'hFFFFFFFF);
    rd_chk(OFF_CALIB, 32'h000009C4, "calib");
    wr(OFF_CSR, 32'hFFFF0000);
    rd_chk(OFF_CSR, 32'h00000000, "csr_unused");
    apb(12'h020, 1'b0, 32'h00000000, 4'h0, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h00000001);
    chk("unmapped_data", r, 32'h00000000);
  endtask

  task automatic sc_reload();
    logic [31:0] r;
    logic e;
    wr(OFF_RELOAD, 32'hFFFFFFFF);
    rd_chk(OFF_RELOAD, 32'h00FFFFFF, "reload_rw");
    apb(OFF_RELOAD, 1'b1, 32'h00000000, 4'h1, r, e);
    rd_chk(OFF_RELOAD, 32'h00FFFF00, "reload_strb");
  endtask

  task automatic sc_cpu_clock();
    int n;
    wr(OFF_RELOAD, 32'h00000005);
    wr(OFF_CSR, 32'h00000007);
    wait_pend(n, 40);
    wait_pend(n, 40);
    chk("cpu_period", n, 32'h00000006);
    wr(OFF_CSR, 32'h00000006);
    rd_chk(OFF_CSR, 32'h00010006, "flag_set");
    rd_chk(OFF_CSR, 32'h00000006, "flag_read_clear");
  endtask

  task automatic sc_clear();
    logic [31:0] r;
    logic [31:0] r2;
    logic e;
    int p0;
    p0 = pend_cnt;
    wr(OFF_RELOAD, 32'h00000100);
    wr(OFF_CSR, 32'h00000005);
    apb(OFF_CURRENT, 1'b0, 32'h00000000, 4'h0, r, e);
    chk("load_on_enable", {31'h0, r <= 32'h00000100 && r >= 32'h000000F0}, 32'h00000001);
    repeat (300) @(posedge pclk);
    wr(OFF_CSR, 32'h00000004);
    apb(OFF_CURRENT, 1'b0, 32'h00000000, 4'h0, r, e);
    apb(OFF_CURRENT, 1'b0, 32'h00000000, 4'h0, r2, e);
    chk("stopped_count", r2, r);
    wr(OFF_CURRENT, 32'hFFFFFFFF);
    rd_chk(OFF_CURRENT, 32'h00000000, "current_clear");
    rd_chk(OFF_CSR, 32'h00000004, "flag_by_clear");
    chk("no_pend", pend_cnt, p0);
  endtask

  task automatic sc_ref_clock();
    int n;
    osc_run <= 1'b1;
    wr(OFF_RELOAD, 32'h00000002);
    wr(OFF_CSR, 32'h00000003);
    wait_pend(n, 1000);
    wait_pend(n, 1000);
    chk("ref_period", n, 32'h00000180);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    sc_reset_map();
    sc_reload();
    sc_cpu_clock();
    sc_clear();
    sc_ref_clock();
    tally_and_finish();
  end
endmodule // tb
